// file: rtl/sas_pkg.sv
`default_nettype none
package sas_pkg;
  // ---------------------------------------------------------------
  // timing in machine cycles
  // ---------------------------------------------------------------
  localparam int unsigned MC_OSC_PER     = 12;
  localparam int unsigned RES_W          = 10;
  localparam int unsigned FAST_W         = 8;
  localparam logic [3:0]  INIT_MC        = 4'h2;
  localparam logic [3:0]  SAMPLE_MC      = 4'h8;
  localparam logic [3:0]  FAST_SAMPLE_MC = 4'h6;
  localparam logic [3:0]  BIT_MC         = 4'h4;
  localparam logic [3:0]  FAST_BIT_MC    = 4'h2;
  localparam logic [5:0]  CONV_MC        = 6'h32;
  localparam logic [5:0]  FAST_CONV_MC   = 6'h18;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_RES_HIGH = 12'h004;
  localparam logic [11:0] OFF_AUX      = 12'h008;
  localparam int unsigned CTL_RES1     = 7;
  localparam int unsigned CTL_RES0     = 6;
  localparam int unsigned CTL_EXT_EN   = 5;
  localparam int unsigned CTL_DONE     = 4;
  localparam int unsigned CTL_START    = 3;
  localparam int unsigned CTL_CHAN_LSB = 0;
  localparam int unsigned CHAN_W       = 3;
  localparam int unsigned AUX_FAST     = 7;
  localparam int unsigned AUX_IDLE_OP  = 6;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  RES_RST      = 8'h00;
  localparam logic [7:0]  AUX_RST      = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INIT,
    ST_SAMPLE,
    ST_CONV
  } sas_state_e;
endpackage : sas_pkg
`default_nettype wire

// file: rtl/sas_mc_tick.sv
`default_nettype none
module sas_mc_tick #(
  parameter int unsigned DIV = 12
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  output logic      tick_o
);
  // ---------------------------------------------------------------
  // one pulse at the end of every machine cycle
  // ---------------------------------------------------------------
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt_q == LAST) begin
        cnt_q  <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 1'b1;
        tick_o <= 1'b0;
      end
    end
  end
endmodule // sas_mc_tick
`default_nettype wire

// file: rtl/sas_sar.sv
`default_nettype none
module sas_sar #(
  parameter int unsigned W       = 10,
  parameter int unsigned SHORT_W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic         step_i,
  input  wire logic         comp_gt_i,
  input  wire logic         short_i,
  output logic [W-1:0]      code_o,
  output logic              last_o,
  output logic [W-1:0]      final_o
);
  // ---------------------------------------------------------------
  // successive approximation register with one-hot bit pointer
  // ---------------------------------------------------------------
  localparam logic [W-1:0] MSB_ONLY = {1'b1, {(W-1){1'b0}}};
  logic [W-1:0] ptr_q;

  // bit under test kept only when the input lies at or above the dac level
  assign final_o = code_o & ~(ptr_q & {W{~comp_gt_i}});
  assign last_o  = short_i ? ptr_q[W-SHORT_W] : ptr_q[0];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_o <= '0;
      ptr_q  <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        code_o <= MSB_ONLY;
        ptr_q  <= MSB_ONLY;
      end else if (step_i) begin
        code_o <= final_o | (ptr_q >> 1);
        ptr_q  <= ptr_q >> 1;
      end
    end
  end
endmodule // sas_sar
`default_nettype wire

// file: rtl/sas_adc_seq.sv
// Summary of operation
// RULE1 - enable clear: only software start bit starts
// RULE2 - enable set: software or pin rising edge
// RULE3 - trigger holds pin low, then high, each cycle
// RULE4 - pin edge seen at cycle end, start next
// RULE5 - software start begins at next machine cycle
// RULE6 - start bit: command flop plus read busy flag
// RULE7 - two init cycles, busy after first
// RULE8 - eight machine cycles sample selected channel
// RULE9 - first trial code is msb only, compare
// RULE10 - each lower bit tested, four cycles per bit
// RULE11 - upper eight to result high, two low bits
// RULE12 - done set, busy cleared, 50 or 24
// RULE13 - fast mode: eight bits in 24 cycles
// RULE14 - control bits 2..0 select analog channel
// RULE15 - starts ignored while conversion in progress
// RULE16 - idle or power-down aborts, keeps result
// RULE17 - idle operation bit keeps converter on idle
// RULE18 - result is straight binary, full scale 3FF
// RULE19 - hardware never clears completion flag
// RULE20 - software may clear, never set, done flag
// RULE21 - machine cycle is twelve oscillator periods
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`default_nettype none
module sas_adc_seq
  import sas_pkg::*;
#(
  parameter int unsigned MC_DIV = MC_OSC_PER,
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              ext_start_pin_i,
  input  wire logic              comp_gt_i,
  input  wire logic              idle_i,
  input  wire logic              pd_i,
  output logic      [CHAN_W-1:0] chan_sel_o,
  output logic      [RES_W-1:0]  dac_code_o,
  output logic                   sample_o,
  output logic                   adc_power_o,
  output logic                   conv_done_o,
  output logic                   conv_busy_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sas_state_e        state_q;
  logic [3:0]        phase_q;
  logic              tick_raw;
  logic              tick_ce;
  logic              ext_lvl_q;
  logic              ext_en_q;
  logic              cmd_q;
  logic              busy_q;
  logic              done_q;
  logic [CHAN_W-1:0] chan_q;
  logic [1:0]        res_low_q;
  logic [7:0]        res_high_q;
  logic              fast_q;
  logic              idle_op_q;
  logic              conv_fast_q;
  logic              samp_q;
  logic              pwr_q;
  logic              pready_q;
  logic [7:0]        prdata_q;
  logic              pslverr_q;
  logic [RES_W-1:0]  final_code;
  logic              sar_last;
  logic              acc;
  logic              wr_fire;
  logic              hit_ctl;
  logic              hit_res;
  logic              hit_aux;
  logic              wr_ctl;
  logic              wr_aux;
  logic [7:0]        wdat;
  logic [7:0]        rd_data;
  logic              ext_edge;
  logic              ext_trig;
  logic              sw_start;
  logic              conv_off;
  logic              abort;
  logic              go;
  logic [3:0]        samp_last;
  logic [3:0]        bit_last;
  logic              sar_step;
  logic              done_set;
  logic [5:0]        total_mc_q;

  // ---------------------------------------------------------------
  // machine cycle timing
  // ---------------------------------------------------------------
  sas_mc_tick #(
    .DIV (MC_DIV)
  ) u_tick (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .tick_o  (tick_raw)
  );

  assign tick_ce = tick_raw & ce_i; // RULE21

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign acc     = psel_i & penable_i;
  assign wr_fire = acc & pwrite_i & pready_q & ce_i;
  assign hit_ctl = (paddr_i == ADDR_W'(OFF_CTRL));
  assign hit_res = (paddr_i == ADDR_W'(OFF_RES_HIGH));
  assign hit_aux = (paddr_i == ADDR_W'(OFF_AUX));
  assign wdat    = pwdata_i[7:0];
  assign wr_ctl  = wr_fire & hit_ctl & pstrb_i[0];
  assign wr_aux  = wr_fire & hit_aux & pstrb_i[0];

  always_comb begin
    rd_data = 8'h00;
    if (hit_ctl) begin
      // start bit reads back the busy flag, not the command flop
      rd_data = {res_low_q, ext_en_q, done_q, busy_q, chan_q}; // RULE6
    end else if (hit_res) begin
      rd_data = res_high_q;
    end else if (hit_aux) begin
      rd_data[AUX_FAST]    = fast_q;
      rd_data[AUX_IDLE_OP] = idle_op_q;
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 8'h00;
      pslverr_q <= 1'b0;
    end else if (ce_i) begin
      if (acc && !pready_q) begin
        pready_q  <= 1'b1;
        prdata_q  <= rd_data;
        pslverr_q <= ~(hit_ctl | hit_res | hit_aux);
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata_o  = {24'h000000, prdata_q};
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  // ---------------------------------------------------------------
  // start requests
  // ---------------------------------------------------------------
  assign ext_edge = tick_ce & ext_start_pin_i & ~ext_lvl_q; // RULE4
  assign ext_trig = ext_en_q & ext_edge; // RULE1 RULE2
  assign sw_start = wr_ctl & wdat[CTL_START];
  // converter is unpowered in power-down, and in idle unless kept on
  assign conv_off = pd_i | (idle_i & ~idle_op_q); // RULE17
  assign abort    = conv_off & ((state_q != ST_IDLE) | cmd_q); // RULE16
  // software start waits for the next machine-cycle boundary
  assign go = tick_ce & (state_q == ST_IDLE) & ~conv_off
              & (cmd_q | ext_trig); // RULE5 RULE4

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_lvl_q <= 1'b0;
    end else if (tick_ce) begin
      ext_lvl_q <= ext_start_pin_i;
    end
  end

  // command flop: set by a start only while nothing is running
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_q <= 1'b0;
    end else if (ce_i) begin
      if (abort || done_set) begin
        cmd_q <= 1'b0;
      end else if ((sw_start || ext_trig) && state_q == ST_IDLE) begin
        cmd_q <= 1'b1; // RULE6 RULE15
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  assign samp_last = (conv_fast_q ? FAST_SAMPLE_MC : SAMPLE_MC) - 4'h1;
  assign bit_last  = (conv_fast_q ? FAST_BIT_MC : BIT_MC) - 4'h1;
  assign sar_step  = tick_ce & (state_q == ST_CONV)
                     & (phase_q == bit_last); // RULE10
  assign done_set  = sar_step & sar_last & ~abort;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q     <= ST_IDLE;
      phase_q     <= 4'h0;
      conv_fast_q <= 1'b0;
      samp_q      <= 1'b0;
    end else if (ce_i) begin
      if (abort) begin
        state_q <= ST_IDLE; // RULE16
        phase_q <= 4'h0;
        samp_q  <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (go) begin
              state_q     <= ST_INIT;
              phase_q     <= 4'h0;
              conv_fast_q <= fast_q; // RULE13
            end
          end
          ST_INIT: begin
            if (tick_ce) begin
              if (phase_q == INIT_MC - 4'h1) begin
                state_q <= ST_SAMPLE; // RULE7
                phase_q <= 4'h0;
                samp_q  <= 1'b1;
              end else begin
                phase_q <= phase_q + 4'h1;
              end
            end
          end
          ST_SAMPLE: begin
            if (tick_ce) begin
              if (phase_q == samp_last) begin
                state_q <= ST_CONV; // RULE8
                phase_q <= 4'h0;
                samp_q  <= 1'b0;
              end else begin
                phase_q <= phase_q + 4'h1;
              end
            end
          end
          ST_CONV: begin
            if (tick_ce) begin
              if (phase_q == bit_last) begin
                phase_q <= 4'h0;
                if (sar_last) begin
                  state_q <= ST_IDLE;
                end
              end else begin
                phase_q <= phase_q + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  sas_sar #(
    .W       (RES_W),
    .SHORT_W (FAST_W)
  ) u_sar (
    .clk_i     (core_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .load_i    (go), // RULE9
    .step_i    (sar_step),
    .comp_gt_i (comp_gt_i),
    .short_i   (conv_fast_q),
    .code_o    (dac_code_o),
    .last_o    (sar_last),
    .final_o   (final_code)
  );

  // ---------------------------------------------------------------
  // status flags and result
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
    end else if (ce_i) begin
      if (abort || done_set) begin
        busy_q <= 1'b0; // RULE12
      end else if (tick_ce && state_q == ST_INIT && phase_q == 4'h0) begin
        busy_q <= 1'b1; // RULE7
      end
    end
  end

  // set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_q <= CTRL_RST[CTL_DONE];
    end else if (ce_i) begin
      if (done_set) begin
        done_q <= 1'b1; // RULE12 RULE19
      end else if (wr_ctl && !wdat[CTL_DONE]) begin
        done_q <= 1'b0; // RULE20
      end
    end
  end

  // straight binary code, upper byte and two low bits
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_high_q <= RES_RST;
      res_low_q  <= CTRL_RST[CTL_RES1:CTL_RES0];
    end else if (ce_i && done_set) begin
      res_high_q <= final_code[RES_W-1:RES_W-FAST_W]; // RULE11 RULE18
      res_low_q  <= conv_fast_q ? 2'h0 : final_code[1:0]; // RULE11
    end
  end

  // ---------------------------------------------------------------
  // software controls
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_en_q <= CTRL_RST[CTL_EXT_EN];
      chan_q   <= CTRL_RST[CTL_CHAN_LSB +: CHAN_W];
    end else if (wr_ctl) begin
      ext_en_q <= wdat[CTL_EXT_EN];
      chan_q   <= wdat[CTL_CHAN_LSB +: CHAN_W]; // RULE14
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast_q    <= AUX_RST[AUX_FAST];
      idle_op_q <= AUX_RST[AUX_IDLE_OP];
    end else if (wr_aux) begin
      fast_q    <= wdat[AUX_FAST];
      idle_op_q <= wdat[AUX_IDLE_OP];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_q <= 1'b0;
    end else if (ce_i) begin
      pwr_q <= ~conv_off; // RULE17
    end
  end

  assign chan_sel_o  = chan_q;
  assign sample_o    = samp_q;
  assign adc_power_o = pwr_q;
  assign conv_done_o = done_q;
  assign conv_busy_o = busy_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      total_mc_q <= 6'h00;
    end else if (go) begin
      total_mc_q <= 6'h00;
    end else if (tick_ce && state_q != ST_IDLE) begin
      total_mc_q <= total_mc_q + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_first_init_end;
    tick_ce && state_q == ST_INIT && phase_q == 4'h0 && !abort;
  endsequence
  sequence s_busy_up;
    busy_q && total_mc_q == 6'h01;
  endsequence
  sequence s_sample_end;
    tick_ce && state_q == ST_SAMPLE && phase_q == samp_last && !abort;
  endsequence

  chk_sw_only_start: assert property ( // RULE1
    (tick_ce && state_q == ST_IDLE && !cmd_q && !ext_en_q)
    |=> state_q == ST_IDLE)
    else $error("conversion started without software start");

  chk_ext_edge_start: assert property ( // RULE2
    (ext_edge && ext_en_q && state_q == ST_IDLE && !conv_off)
    |=> state_q == ST_INIT && cmd_q)
    else $error("pin rising edge did not start conversion");

  chk_busy_after_init: assert property ( // RULE7
    s_first_init_end |=> s_busy_up)
    else $error("busy flag not set after first init cycle");

  chk_sar_first_trial: assert property ( // RULE9
    s_sample_end |=> dac_code_o == 10'h200 && state_q == ST_CONV)
    else $error("first trial code is not msb only");

  chk_conv_length: assert property ( // RULE12
    done_set |=> done_q && !busy_q
      && total_mc_q == (conv_fast_q ? FAST_CONV_MC : CONV_MC))
    else $error("conversion length wrong");

  chk_fast_low_zero: assert property ( // RULE13
    (done_set && conv_fast_q) |=> res_low_q == 2'h0)
    else $error("fast mode left low result bits set");

  chk_no_restart: assert property ( // RULE15
    (state_q != ST_IDLE && !abort) |=> state_q != ST_INIT
      || $past(state_q) == ST_INIT)
    else $error("start accepted during conversion");

  chk_abort_idle: assert property ( // RULE16
    (abort && ce_i) |=> state_q == ST_IDLE && !busy_q && !cmd_q
      && $stable(res_high_q))
    else $error("abort did not stop conversion");

  chk_done_sticky: assert property ( // RULE19
    (done_q && !(wr_ctl && !wdat[CTL_DONE])) |=> done_q)
    else $error("completion flag cleared by hardware");

  chk_done_no_sw_set: assert property ( // RULE20
    (!done_q && !done_set) |=> !done_q)
    else $error("completion flag set without completion");
endmodule // sas_adc_seq
`default_nettype wire

// file: sim/sas_far_model.sv
`default_nettype none
module sas_far_model
  import sas_pkg::*;
#(
  parameter int unsigned MC = 3
) (
  input  wire logic                  clk_i,
  input  wire logic                  fire_i,
  input  wire logic [CHAN_W-1:0]     chan_i,
  input  wire logic [RES_W-1:0]      dac_i,
  input  wire logic [7:0][RES_W-1:0] lvl_i,
  output logic                       comp_gt_o,
  output logic                       pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;

  // ---------------------------------------------------------------
  // analog side: level per channel in ladder code steps
  // ---------------------------------------------------------------
  assign comp_gt_o = (lvl_i[chan_i] >= dac_i);

  // ---------------------------------------------------------------
  // trigger source: low two machine cycles, then high until next
  // ---------------------------------------------------------------
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    if (fire_i) begin
      pin_o <= 1'b0;
      cnt <= 2 * MC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        pin_o <= 1'b1;
      end
    end
  end
endmodule // sas_far_model
`default_nettype wire

// file: sim/sar_adc_sequencer_bench.sv
`default_nettype none
module sar_adc_sequencer_bench
  import sas_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MC = 3;
  typedef struct packed {
    logic [7:0] aux;
    logic [2:0] ch;
    logic [9:0] lv;
    logic [7:0] hi;
    logic [1:0] lo;
  } sas_row_s;
  // ---------------------------------------------------------------
  // rows: mode, channel, level in; result high and low bits out
  // ---------------------------------------------------------------
  sas_row_s rows [8] = '{
    '{8'h00, 3'h0, 10'h000, 8'h00, 2'h0},
    '{8'h00, 3'h1, 10'h3FF, 8'hFF, 2'h3},
    '{8'h00, 3'h2, 10'h201, 8'h80, 2'h1},
    '{8'h00, 3'h3, 10'h1FE, 8'h7F, 2'h2},
    '{8'h80, 3'h4, 10'h155, 8'h55, 2'h0},
    '{8'h00, 3'h5, 10'h2AA, 8'hAA, 2'h2},
    '{8'h80, 3'h6, 10'h3FF, 8'hFF, 2'h0},
    '{8'h00, 3'h7, 10'h0C3, 8'h30, 2'h3}
  };
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [31:0]     pwdata = 32'h0000_0000;
  logic [3:0]      pstrb = 4'hF;
  logic            idle = 1'b0;
  logic            pd = 1'b0;
  logic            fire = 1'b0;
  logic            ce = 1'b1;
  logic [7:0][9:0] lvl = 80'h0;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, perr, pin, comp_gt, sample;
  logic            adc_pwr, conv_done, conv_busy;
  logic [2:0]      chan_sel;
  logic [9:0]      dac_code;
  int              err_count = 0;
  int              n_tests = 0;
  int              cyc = 0, s_cnt = 0, t_bsy = 0, t_dn = 0, n;
  bit              bsy_d, dn_d;

  sas_adc_seq #(.MC_DIV(MC), .ADDR_W(12)) dut (
    .core_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_start_pin_i(pin),
    .comp_gt_i(comp_gt), .idle_i(idle), .pd_i(pd),
    .chan_sel_o(chan_sel), .dac_code_o(dac_code), .sample_o(sample),
    .adc_power_o(adc_pwr), .conv_done_o(conv_done),
    .conv_busy_o(conv_busy));
  sas_far_model #(.MC(MC)) far (
    .clk_i(clk), .fire_i(fire), .chan_i(chan_sel), .dac_i(dac_code),
    .lvl_i(lvl), .comp_gt_o(comp_gt), .pin_o(pin));

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // monitor: edge times of busy and done, sampling length
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (sample === 1'b1) s_cnt++;
    if (conv_busy === 1'b1 && !bsy_d) t_bsy = cyc;
    if (conv_done === 1'b1 && !dn_d) t_dn = cyc;
    bsy_d = (conv_busy === 1'b1);
    dn_d = (conv_done === 1'b1);
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // edge first, so a release is never overridden in one time step
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_sig(input bit dn, input int lim, output int k);
    k = 0;
    while (((dn ? conv_done : conv_busy) !== 1'b1) && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(k < lim, 1);
    @(posedge clk);
  endtask

  task automatic fire_pin();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(0, OFF_CTRL, 8'h00);
    chk(rd, 32'(CTRL_RST));
    apb(0, OFF_AUX, 8'h00);
    chk(rd, 32'(AUX_RST));
    foreach (rows[i]) begin
      if (i > 0) chk(conv_done, 1);
      lvl[rows[i].ch] <= rows[i].lv;
      apb(1, OFF_AUX, rows[i].aux);
      apb(1, OFF_CTRL, {5'h01, rows[i].ch});
      s_cnt = 0;
      wait_sig(0, 4 * MC, n);
      chk(n <= 2 * MC + 1, 1);
      chk(dac_code, 10'h200);
      apb(1, OFF_CTRL, {5'h01, rows[i].ch});
      wait_sig(1, 60 * MC, n);
      chk(t_dn - t_bsy, rows[i].aux[AUX_FAST] ? 23 * MC : 49 * MC);
      chk(conv_busy, 0);
      chk(s_cnt, rows[i].aux[AUX_FAST] ? 6 * MC : 8 * MC);
      chk(chan_sel, rows[i].ch);
      apb(0, OFF_RES_HIGH, 8'h00);
      chk(rd, rows[i].hi);
      apb(0, OFF_CTRL, 8'h00);
      chk(rd, {24'h00_0000, rows[i].lo, 3'h2, rows[i].ch});
    end
    repeat (10 * MC) @(posedge clk);
    chk(conv_done, 1);
    apb(1, OFF_CTRL, 8'h07);
    @(posedge clk);
    chk(conv_done, 0);
    apb(1, OFF_CTRL, 8'h17);
    @(posedge clk);
    chk(conv_done, 0);
    pstrb <= 4'hE;
    apb(1, OFF_CTRL, 8'h02);
    pstrb <= 4'hF;
    apb(0, OFF_CTRL, 8'h00);
    chk(rd, 32'h0000_00C7);
    apb(1, OFF_RES_HIGH, 8'h5A);
    apb(0, OFF_RES_HIGH, 8'h00);
    chk(rd, 32'h0000_0030);
    apb(0, 12'h00C, 8'h00);
    chk(perr, 1);
    chk(rd, 0);
    apb(1, OFF_CTRL, 8'h02);
    fire_pin();
    repeat (5 * MC) @(posedge clk);
    chk(conv_busy, 0);
    apb(1, OFF_CTRL, 8'h22);
    fire_pin();
    wait_sig(0, 6 * MC, n);
    chk(n >= 2 * MC && n <= 4 * MC + 1, 1);
    wait_sig(1, 60 * MC, n);
    apb(0, OFF_RES_HIGH, 8'h00);
    chk(rd, 32'h0000_0080);
    apb(1, OFF_CTRL, 8'h39);
    wait_sig(0, 4 * MC, n);
    idle <= 1'b1;
    repeat (2 * MC) @(posedge clk);
    chk({conv_busy, adc_pwr, conv_done}, 3'h1);
    apb(0, OFF_RES_HIGH, 8'h00);
    chk(rd, 32'h0000_0080);
    idle <= 1'b0;
    apb(1, OFF_AUX, 8'h40);
    apb(1, OFF_CTRL, 8'h09);
    wait_sig(0, 4 * MC, n);
    idle <= 1'b1;
    wait_sig(1, 60 * MC, n);
    chk(adc_pwr, 1);
    apb(0, OFF_RES_HIGH, 8'h00);
    chk(rd, 32'h0000_00FF);
    idle <= 1'b0;
    apb(1, OFF_CTRL, 8'h0B);
    wait_sig(0, 4 * MC, n);
    ce <= 1'b0;
    repeat (20 * MC) @(posedge clk);
    chk({conv_busy, dac_code}, {1'b1, 10'h200});
    ce <= 1'b1;
    wait_sig(1, 60 * MC, n);
    chk(t_dn - t_bsy, 69 * MC);
    apb(1, OFF_CTRL, 8'h0A);
    wait_sig(0, 4 * MC, n);
    pd <= 1'b1;
    repeat (2 * MC) @(posedge clk);
    chk({conv_busy, adc_pwr, conv_done}, 3'h0);
    pd <= 1'b0;
    apb(1, OFF_CTRL, 8'h0C);
    wait_sig(0, 4 * MC, n);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    apb(0, OFF_CTRL, 8'h00);
    chk(rd, 32'(CTRL_RST));
    chk(dac_code, 0);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule // sar_adc_sequencer_bench
`default_nettype wire
